// [core/suc_pkg.sv]
// constants and types shared by the stage and up/down counter block
package suc_pkg;

  // ==========================================================
  // timing
  localparam int CLK_NS = 10;
  localparam int SCAN_NS = 10000;
  localparam int SCAN_CYC_DFLT = SCAN_NS / CLK_NS;
  localparam int SCAN_CYC_MIN = 16;

  // ==========================================================
  // widths
  localparam int WORD_W = 16;
  localparam int SG_W = 14;
  localparam int UD_W = 27;
  localparam int CTR_NUM_W = 9;
  localparam int UD_HI_W = UD_W - WORD_W;

  // ==========================================================
  // value limits and reset values
  localparam logic [SG_W-1:0] SG_MAX = 14'h270f;
  localparam logic [UD_W-1:0] UD_MAX = 27'h5f5e0ff;
  localparam logic [SG_W-1:0] SG_ZERO = 14'h0000;
  localparam logic [UD_W-1:0] UD_ZERO = 27'h0000000;
  localparam logic [SG_W-1:0] SG_ONE = 14'h0001;
  localparam logic [UD_W-1:0] UD_ONE = 27'h0000001;

  // ==========================================================
  // value memory layout
  localparam logic [WORD_W-1:0] VAL_BASE = 16'h03e8;
  localparam logic [WORD_W-1:0] UD_HI_OFS = 16'h0001;

  // ==========================================================
  // preset source select
  localparam logic PRE_SRC_K = 1'b0;
  localparam logic PRE_SRC_MEM = 1'b1;

  // ==========================================================
  // ladder-side control levels
  typedef struct packed {
    logic count;
    logic rst_cmd;
    logic stage_on;
    logic pre_sel;
  } suc_sg_ctl_type;

  typedef struct packed {
    logic up;
    logic down;
    logic rst;
    logic pre_sel;
  } suc_ud_ctl_type;

endpackage

// [core/suc_top.sv]
// scan-driven stage counter and bidirectional counter with value memory
//
// What this block does
// - stage counter adds one on each off-to-on change of its count input while its stage is on and was on the scan before.
// - stage counter holds its value until an explicit reset command.
// - stage counter keeps counting past preset but never above 9999.
// - at 9999 the stage counter holds despite further count edges.
// - status bit is on when value is at or above preset.
// - stage status bit stays on once set until reset command.
// - stage reset clears status bit and sets value to zero.
// - current value sits in value memory at counter number plus 1000.
// - stage preset comes from a constant or a value-memory word.
// - bidirectional counter adds one on each count-up rising edge.
// - bidirectional counter subtracts one on each count-down rising edge.
// - bidirectional counter held at zero while its reset level is on.
// - bidirectional counter range is zero to 99999999.
// - an edge counts only while the opposite count input is off.
// - bidirectional value is a double word in two consecutive words.
// - bidirectional preset is a constant or two consecutive words.
`timescale 1ns/1ns
`default_nettype none

module suc_top import suc_pkg::*; #(
  parameter int ADDR_W = 13,
  parameter int SCAN_CYC = SCAN_CYC_DFLT,
  parameter logic [CTR_NUM_W-1:0] SG_NUM = 9'h002,
  parameter logic [CTR_NUM_W-1:0] UD_NUM = 9'h004
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // stage counter, ladder side
  input wire suc_sg_ctl_type sg_ctl,
  input wire logic [SG_W-1:0] sg_pre_k,
  input wire logic [ADDR_W-1:0] sg_pre_addr,
  // bidirectional counter, ladder side
  input wire suc_ud_ctl_type ud_ctl,
  input wire logic [UD_W-1:0] ud_pre_k,
  input wire logic [ADDR_W-1:0] ud_pre_addr,
  // value memory access for operator terminal
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic [ADDR_W-1:0] ext_addr,
  input wire logic [WORD_W-1:0] ext_wdata,
  output logic ext_ack,
  output logic [WORD_W-1:0] ext_rdata,
  // counter results
  output logic sg_status,
  output logic [SG_W-1:0] sg_value,
  output logic ud_status,
  output logic [UD_W-1:0] ud_value,
  output logic scan_done
);

  // ==========================================================
  // elaboration checks
  localparam int DIV_W = $clog2(SCAN_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCAN_CYC - 1);

  generate
    if (SCAN_CYC < SCAN_CYC_MIN) begin : g_bad_scan
      $error("scan period too short for one update pass");
    end
    if (ADDR_W < 11 || ADDR_W > WORD_W) begin : g_bad_aw
      $error("value memory address width out of range");
    end
    if (SG_NUM == UD_NUM || SG_NUM == UD_NUM + 9'h001) begin : g_bad_num
      $error("stage counter overlaps the double-word counter");
    end
    if (int'(VAL_BASE) + int'(UD_NUM) + 1 >= (2 ** ADDR_W) ||
        int'(VAL_BASE) + int'(SG_NUM) >= (2 ** ADDR_W)) begin : g_bad_map
      $error("counter value words fall outside the value memory");
    end
  endgenerate

  // ==========================================================
  // helpers
  function automatic logic [ADDR_W-1:0] val_addr(
      input logic [CTR_NUM_W-1:0] num);
    val_addr = ADDR_W'(VAL_BASE + {7'h00, num});
  endfunction

  function automatic logic rise(input logic now, input logic last);
    rise = now & ~last;
  endfunction

  // ==========================================================
  // scan sequencer states
  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_EXT   = 10'h002,
    ST_RD_SG = 10'h004,
    ST_RD_UL = 10'h008,
    ST_RD_UH = 10'h010,
    ST_RD_END = 10'h020,
    ST_EVAL  = 10'h040,
    ST_WR_SG = 10'h080,
    ST_WR_UL = 10'h100,
    ST_WR_UH = 10'h200
  } suc_state_type;

  suc_state_type state_r;
  suc_state_type state_nxt;

  // ==========================================================
  // input synchronisers
  suc_sg_ctl_type sg_meta_r;
  suc_sg_ctl_type sg_sync_r;
  suc_ud_ctl_type ud_meta_r;
  suc_ud_ctl_type ud_sync_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sg_meta_r <= '0;
      sg_sync_r <= '0;
      ud_meta_r <= '0;
      ud_sync_r <= '0;
    end else begin
      sg_meta_r <= sg_ctl;
      sg_sync_r <= sg_meta_r;
      ud_meta_r <= ud_ctl;
      ud_sync_r <= ud_meta_r;
    end
  end

  // ==========================================================
  // scan divider
  logic [DIV_W-1:0] div_r;
  logic scan_tick_r;
  logic scan_pend_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      div_r <= '0;
      scan_tick_r <= 1'b0;
    end else begin
      scan_tick_r <= (div_r == DIV_LAST);
      if (div_r == DIV_LAST) begin
        div_r <= '0;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // a tick that lands during a terminal access waits here
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scan_pend_r <= 1'b0;
    end else if (scan_tick_r) begin
      scan_pend_r <= 1'b1;
    end else if (state_r == ST_IDLE) begin
      scan_pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (scan_pend_r) begin
          state_nxt = ST_RD_SG;
        end else if (ext_req) begin
          state_nxt = ST_EXT;
        end
      end
      ST_EXT: state_nxt = ST_IDLE;
      ST_RD_SG: state_nxt = ST_RD_UL;
      ST_RD_UL: state_nxt = ST_RD_UH;
      ST_RD_UH: state_nxt = ST_RD_END;
      ST_RD_END: state_nxt = ST_EVAL;
      ST_EVAL: state_nxt = ST_WR_SG;
      ST_WR_SG: state_nxt = ST_WR_UL;
      ST_WR_UL: state_nxt = ST_WR_UH;
      ST_WR_UH: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // inputs frozen for one scan
  suc_sg_ctl_type sg_scan_r;
  suc_ud_ctl_type ud_scan_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sg_scan_r <= '0;
      ud_scan_r <= '0;
    end else if (state_r == ST_IDLE && scan_pend_r) begin
      sg_scan_r <= sg_sync_r;
      ud_scan_r <= ud_sync_r;
    end
  end

  // ==========================================================
  // value memory port
  logic mem_we;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] mem_rdata;
  logic [SG_W-1:0] sg_val_r;
  logic [UD_W-1:0] ud_val_r;

  always_comb begin
    mem_we = 1'b0;
    mem_addr = ext_addr;
    mem_wdata = ext_wdata;
    case (state_r)
      ST_IDLE: begin
        mem_we = ext_req & ext_we & ~scan_pend_r;
      end
      ST_RD_SG: mem_addr = sg_pre_addr;
      ST_RD_UL: mem_addr = ud_pre_addr;
      ST_RD_UH: mem_addr = ud_pre_addr + 1'b1;
      ST_WR_SG: begin
        mem_we = 1'b1;
        mem_addr = val_addr(SG_NUM);
        mem_wdata = WORD_W'(sg_val_r);
      end
      ST_WR_UL: begin
        mem_we = 1'b1;
        mem_addr = val_addr(UD_NUM);
        mem_wdata = ud_val_r[WORD_W-1:0];
      end
      ST_WR_UH: begin
        mem_we = 1'b1;
        mem_addr = val_addr(UD_NUM) + ADDR_W'(UD_HI_OFS);
        mem_wdata = WORD_W'(ud_val_r[UD_W-1:WORD_W]);
      end
      default: begin
        mem_we = 1'b0;
      end
    endcase
  end

  suc_vmem #(
    .DW(WORD_W),
    .AW(ADDR_W)
  ) u_vmem (
    .clk_sys(clk_sys),
    .srst(srst),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_r(mem_rdata)
  );

  // ==========================================================
  // terminal answer
  logic ext_ack_r;
  logic [WORD_W-1:0] ext_rdata_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_ack_r <= 1'b0;
      ext_rdata_r <= '0;
    end else begin
      ext_ack_r <= (state_r == ST_EXT);
      if (state_r == ST_EXT) begin
        ext_rdata_r <= mem_rdata;
      end
    end
  end

  // ==========================================================
  // presets for this scan
  logic [SG_W-1:0] sg_pre_mem_r;
  logic [WORD_W-1:0] ud_pre_lo_r;
  logic [UD_HI_W-1:0] ud_pre_hi_r;
  logic [SG_W-1:0] sg_pre;
  logic [UD_W-1:0] ud_pre;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sg_pre_mem_r <= '0;
      ud_pre_lo_r <= '0;
      ud_pre_hi_r <= '0;
    end else begin
      if (state_r == ST_RD_UL) begin
        sg_pre_mem_r <= mem_rdata[SG_W-1:0];
      end
      if (state_r == ST_RD_UH) begin
        ud_pre_lo_r <= mem_rdata;
      end
      if (state_r == ST_RD_END) begin
        ud_pre_hi_r <= mem_rdata[UD_HI_W-1:0];
      end
    end
  end

  assign sg_pre = (sg_scan_r.pre_sel == PRE_SRC_MEM) ?
                  sg_pre_mem_r : sg_pre_k;
  assign ud_pre = (ud_scan_r.pre_sel == PRE_SRC_MEM) ?
                  {ud_pre_hi_r, ud_pre_lo_r} : ud_pre_k;

  // ==========================================================
  // stage counter evaluation
  logic sg_prev_r;
  logic sg_armed_r;
  logic sg_stat_r;
  logic sg_edge;
  logic [SG_W-1:0] sg_val_nxt;
  logic sg_stat_nxt;

  // the stage must have run one scan first, so an input already on
  // when the stage turns on is not taken as an edge
  assign sg_edge = sg_scan_r.stage_on & sg_armed_r &
                   rise(sg_scan_r.count, sg_prev_r);

  always_comb begin
    sg_val_nxt = sg_val_r;
    sg_stat_nxt = sg_stat_r;
    if (sg_scan_r.rst_cmd) begin
      sg_val_nxt = SG_ZERO;
      sg_stat_nxt = 1'b0;
    end else begin
      if (sg_edge && sg_val_r < SG_MAX) begin
        sg_val_nxt = sg_val_r + SG_ONE;
      end
      // sticky: a raised preset never turns it off
      sg_stat_nxt = sg_stat_r | (sg_val_nxt >= sg_pre);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sg_val_r <= SG_ZERO;
      sg_stat_r <= 1'b0;
      sg_prev_r <= 1'b0;
      sg_armed_r <= 1'b0;
    end else if (state_r == ST_EVAL) begin
      sg_val_r <= sg_val_nxt;
      sg_stat_r <= sg_stat_nxt;
      sg_prev_r <= sg_scan_r.count;
      sg_armed_r <= sg_scan_r.stage_on;
    end
  end

  // ==========================================================
  // bidirectional counter evaluation
  logic ud_up_prev_r;
  logic ud_dn_prev_r;
  logic ud_stat_r;
  logic ud_up_edge;
  logic ud_dn_edge;
  logic [UD_W-1:0] ud_val_nxt;

  // an edge is ignored while the opposite input is on
  assign ud_up_edge = rise(ud_scan_r.up, ud_up_prev_r) &
                      ~ud_scan_r.down;
  assign ud_dn_edge = rise(ud_scan_r.down, ud_dn_prev_r) &
                      ~ud_scan_r.up;

  always_comb begin
    ud_val_nxt = ud_val_r;
    if (ud_scan_r.rst) begin
      ud_val_nxt = UD_ZERO;
    end else if (ud_up_edge && ud_val_r < UD_MAX) begin
      ud_val_nxt = ud_val_r + UD_ONE;
    end else if (ud_dn_edge && ud_val_r != UD_ZERO) begin
      ud_val_nxt = ud_val_r - UD_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ud_val_r <= UD_ZERO;
      ud_stat_r <= 1'b0;
      ud_up_prev_r <= 1'b0;
      ud_dn_prev_r <= 1'b0;
    end else if (state_r == ST_EVAL) begin
      ud_val_r <= ud_val_nxt;
      ud_stat_r <= (ud_val_nxt >= ud_pre);
      ud_up_prev_r <= ud_scan_r.up;
      ud_dn_prev_r <= ud_scan_r.down;
    end
  end

  // ==========================================================
  // scan completion
  logic scan_done_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scan_done_r <= 1'b0;
    end else begin
      scan_done_r <= (state_r == ST_WR_UH);
    end
  end

  // ==========================================================
  // outputs
  assign ext_ack = ext_ack_r;
  assign ext_rdata = ext_rdata_r;
  assign sg_status = sg_stat_r;
  assign sg_value = sg_val_r;
  assign ud_status = ud_stat_r;
  assign ud_value = ud_val_r;
  assign scan_done = scan_done_r;

endmodule

`default_nettype wire

// [core/suc_vmem.sv]
// value memory: one port, registered read data
`timescale 1ns/1ns
`default_nettype none

module suc_vmem #(
  parameter int DW = 16,
  parameter int AW = 13
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // access port
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_r
);

  logic [DW-1:0] mem [0:(2**AW)-1];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // read-during-write returns the old word
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem[addr];
    end
  end

endmodule

`default_nettype wire

// [tb/suc_ladder.sv]
// ladder-side model driving counter control levels once per scan
`timescale 1ns/1ns
`default_nettype none

module suc_ladder import suc_pkg::*; (
  // clock and scan handshake
  input wire logic clk_sys,
  input wire logic scan_done,
  // control levels
  output var suc_sg_ctl_type sg_ctl,
  output var suc_ud_ctl_type ud_ctl
);
  initial begin
    sg_ctl = '0;
    ud_ctl = '0;
  end

  // ====
  // one step: set levels, then wait for two write-backs, since the
  // first may close a scan that froze its inputs before the change
  task automatic one(input suc_sg_ctl_type s, input suc_ud_ctl_type u,
                     output bit ok);
    int seen;
    @(posedge clk_sys);
    #1;
    sg_ctl = s;
    ud_ctl = u;
    seen = 0;
    for (int i = 0; i < 100 && seen < 2; i++) begin
      @(posedge clk_sys);
      #1;
      if (scan_done) seen++;
    end
    ok = (seen == 2);
  endtask

  task automatic scan(input suc_sg_ctl_type s, input suc_ud_ctl_type u,
                      output bit ok);
    suc_sg_ctl_type a;
    a = s;
    a.count = 1'b0;
    ok = 1'b1;
    // an edge in a stage opened this scan is lost, so open it one scan early
    if (s.count && s.stage_on && !sg_ctl.stage_on) one(a, u, ok);
    if (ok) one(s, u, ok);
  endtask
endmodule

`default_nettype wire

// [tb/suc_top_props.sv]
// concurrent checks on the counter block's ports
`timescale 1ns/1ns
`default_nettype none

module suc_top_props import suc_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // ladder side
  input wire suc_sg_ctl_type sg_ctl,
  input wire logic [SG_W-1:0] sg_pre_k,
  input wire suc_ud_ctl_type ud_ctl,
  input wire logic [UD_W-1:0] ud_pre_k,
  // terminal
  input wire logic ext_req,
  input wire logic ext_ack,
  // results
  input wire logic sg_status,
  input wire logic [SG_W-1:0] sg_value,
  input wire logic ud_status,
  input wire logic [UD_W-1:0] ud_value,
  input wire logic scan_done
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // ====
  // stage counter
  a_sg_step: assert property (
    $changed(sg_value) |->
      sg_value == SG_ZERO || sg_value == $past(sg_value) + SG_ONE)
    else $error("stage value moved by other than one");
  a_sg_cap: assert property (sg_value <= SG_MAX)
    else $error("stage value above ceiling");
  a_sg_hold_max: assert property (
    sg_value == SG_MAX |=> sg_value == SG_MAX || sg_value == SG_ZERO)
    else $error("stage value left ceiling without reset");
  a_sg_clear: assert property (
    $fell(sg_status) |-> sg_value == SG_ZERO)
    else $error("stage status fell without a clear");
  a_sg_status: assert property (
    scan_done && sg_ctl.pre_sel == PRE_SRC_K && sg_value >= sg_pre_k
      |-> sg_status)
    else $error("stage status low at or above preset");

  // ====
  // bidirectional counter
  a_ud_step: assert property (
    $changed(ud_value) |-> ud_value == UD_ZERO ||
      ud_value == $past(ud_value) + UD_ONE ||
      ud_value == $past(ud_value) - UD_ONE)
    else $error("bidirectional value jumped");
  a_ud_range: assert property (ud_value <= UD_MAX)
    else $error("bidirectional value above range");
  a_ud_status: assert property (
    scan_done && ud_ctl.pre_sel == PRE_SRC_K
      |-> ud_status == (ud_value >= ud_pre_k))
    else $error("bidirectional status disagrees with preset");

  // ====
  // scan and terminal timing
  a_scan_wb: assert property (
    $changed({sg_value, ud_value}) |-> ##3 scan_done)
    else $error("value changed outside a scan evaluation");
  a_ack_pulse: assert property (ext_ack |=> !ext_ack)
    else $error("terminal ack longer than one cycle");
  a_ack_time: assert property (
    ext_req && !$past(ext_req) |-> ##[2:13] ext_ack)
    else $error("terminal ack late");
endmodule

bind suc_top suc_top_props u_props (.clk_sys, .srst, .sg_ctl, .sg_pre_k,
  .ud_ctl, .ud_pre_k, .ext_req, .ext_ack, .sg_status, .sg_value,
  .ud_status, .ud_value, .scan_done);

`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the stage and up/down counters
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, a) \
  begin \
    total_checks++; \
    if ((a) !== (e)) begin \
      miscompares++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, a); \
    end \
  end

module tb_top import suc_pkg::*; ;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [SG_W-1:0] sg_pre_k = 14'h0003;
  logic [UD_W-1:0] ud_pre_k = 27'h0000003;
  logic ext_req = 1'b0;
  logic ext_we = 1'b0;
  logic [12:0] ext_addr = 13'h0000;
  logic [WORD_W-1:0] ext_wdata = 16'h0000;
  logic [WORD_W-1:0] ext_rdata;
  logic [WORD_W-1:0] rd_w;
  logic [SG_W-1:0] sg_value;
  logic [UD_W-1:0] ud_value;
  logic ext_ack;
  logic sg_status;
  logic ud_status;
  logic scan_done;
  suc_sg_ctl_type sg_ctl;
  suc_ud_ctl_type ud_ctl;
  int miscompares = 0;
  int total_checks = 0;
  bit ok;

  always #5 clk_sys = ~clk_sys;

  // short scan keeps the run brief and lets two scans finish inside the ladder's 100-cycle wait
  suc_top #(.SCAN_CYC(20)) u_dut (
    .clk_sys, .srst, .sg_ctl, .sg_pre_k, .sg_pre_addr(13'h0010), .ud_ctl,
    .ud_pre_k, .ud_pre_addr(13'h0020), .ext_req, .ext_we, .ext_addr,
    .ext_wdata, .ext_ack, .ext_rdata, .sg_status, .sg_value, .ud_status,
    .ud_value, .scan_done);

  suc_ladder u_lad (.clk_sys, .scan_done, .sg_ctl, .ud_ctl);

  // ====
  // shared tasks
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic fail(input string what);
    miscompares++;
    $display("MISMATCH %s exp 1 got 0", what);
    test_done;
  endtask

  task automatic sc(input suc_sg_ctl_type s, input suc_ud_ctl_type u);
    u_lad.scan(s, u, ok);
    if (!ok) fail("scan_done");
  endtask

  // request held until ack is seen, then dropped in the ack cycle
  task automatic acc(input logic we, input logic [12:0] a,
                     input logic [WORD_W-1:0] d);
    bit got;
    @(posedge clk_sys);
    #1;
    ext_req = 1'b1;
    ext_we = we;
    ext_addr = a;
    ext_wdata = d;
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(posedge clk_sys);
      #1;
      got = ext_ack;
    end
    rd_w = ext_rdata;
    ext_req = 1'b0;
    if (!got) fail("ext_ack");
  endtask

  task automatic chk_sg(input logic [SG_W-1:0] v, input logic s);
    `CHK("sg_value", v, sg_value)
    `CHK("sg_status", s, sg_status)
  endtask

  task automatic chk_ud(input logic [UD_W-1:0] v, input logic s);
    `CHK("ud_value", v, ud_value)
    `CHK("ud_status", s, ud_status)
  endtask

  // ====
  // stage counter
  task automatic t_stage;
    logic [SG_W-1:0] v;
    v = SG_ZERO;
    chk_sg(v, 1'b0);
    sc(4'b0010, 4'b0000);
    for (int i = 1; i <= 3; i++) begin
      sc(4'b1010, 4'b0000);
      v = v + SG_ONE;
      chk_sg(v, v >= sg_pre_k);
      sc(4'b0010, 4'b0000);
    end
    sc(4'b1010, 4'b0000);
    sc(4'b1010, 4'b0000);
    v = v + SG_ONE;
    chk_sg(v, 1'b1);
    acc(1'b0, 13'h03ea, 16'h0000);
    `CHK("mem_sg", {2'b00, v}, rd_w)
    sc(4'b1000, 4'b0000);
    sc(4'b0000, 4'b0000);
    chk_sg(v, 1'b1);
    // stage opened in the same scan as the edge: nothing is counted
    u_lad.one(4'b1010, 4'b0000, ok);
    if (!ok) fail("scan_done");
    chk_sg(v, 1'b1);
    sc(4'b0010, 4'b0000);
    sg_pre_k = 14'h0064;
    sc(4'b1010, 4'b0000);
    v = v + SG_ONE;
    chk_sg(v, 1'b1);
    sc(4'b0010, 4'b0000);
    sc(4'b1110, 4'b0000);
    chk_sg(SG_ZERO, 1'b0);
    acc(1'b1, 13'h0010, 16'h0002);
    sc(4'b0011, 4'b0000);
    sc(4'b1011, 4'b0000);
    chk_sg(SG_ONE, 1'b0);
    sc(4'b0011, 4'b0000);
    sc(4'b1011, 4'b0000);
    chk_sg(14'h0002, 1'b1);
    $display("t_stage done");
  endtask

  // ====
  // bidirectional counter
  task automatic t_ud;
    logic [UD_W-1:0] v;
    v = UD_ZERO;
    sc(4'b0000, 4'b0000);
    for (int i = 1; i <= 3; i++) begin
      sc(4'b0000, 4'b1000);
      v = v + UD_ONE;
      chk_ud(v, v >= ud_pre_k);
      sc(4'b0000, 4'b0000);
    end
    sc(4'b0000, 4'b0100);
    v = v - UD_ONE;
    chk_ud(v, 1'b0);
    acc(1'b0, 13'h03ec, 16'h0000);
    `CHK("mem_ud_lo", v[15:0], rd_w)
    acc(1'b0, 13'h03ed, 16'h0000);
    `CHK("mem_ud_hi", {5'h00, v[26:16]}, rd_w)
    sc(4'b0000, 4'b1100);
    chk_ud(v, 1'b0);
    sc(4'b0000, 4'b0000);
    sc(4'b0000, 4'b1010);
    chk_ud(UD_ZERO, 1'b0);
    sc(4'b0000, 4'b0010);
    sc(4'b0000, 4'b1010);
    chk_ud(UD_ZERO, 1'b0);
    sc(4'b0000, 4'b0000);
    sc(4'b0000, 4'b0100);
    chk_ud(UD_ZERO, 1'b0);
    acc(1'b1, 13'h0020, 16'h0002);
    acc(1'b1, 13'h0021, 16'h0001);
    for (int i = 0; i < 2; i++) begin
      sc(4'b0000, 4'b0001);
      sc(4'b0000, 4'b1001);
    end
    chk_ud(27'h0000002, 1'b0);
    acc(1'b1, 13'h0021, 16'h0000);
    sc(4'b0000, 4'b0001);
    chk_ud(27'h0000002, 1'b1);
    $display("t_ud done");
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    t_stage;
    t_ud;
    test_done;
  end
endmodule

`default_nettype wire
